// *** core/sosc_top.sv ***
// strap-option startup controller with wishbone status/control registers
// Function
// - straps sampled once after power-up reset; later changes ignored
// - force single-ended strap on: single-ended drivers whatever the sense
// - force strap off lets the differential sense line pick bus mode
// - no delay and no command strap: spindle starts right after power-up
// - command strap only: spindle waits for a start unit command
// - delay strap only: spindle waits bus id times twelve seconds
// - both straps: start on command, id delay ignored
// - write-protect strap on refuses all medium writes
// - parity-disable strap on stops parity checking and error reporting
`include "sosc_consts.svh"
module sosc_top
#(
  parameter logic [`SOSC_CNT_W-1:0] SPIN_STEP_CYC = `SOSC_SPIN_STEP_CYC
)
(
  input  wire logic                  clk_in,                    // 100 MHz
  input  wire logic                  rst_n_in,                  // power-on reset
  input  wire logic                  force_single_ended_strap_in, // jumper on
  input  wire logic                  delayed_spin_strap_in,     // jumper on
  input  wire logic                  motor_start_by_command_strap_in, // jumper
  input  wire logic                  write_protect_strap_in,    // jumper on
  input  wire logic                  parity_disable_strap_in,   // jumper on
  input  wire logic                  reserved_strap_in,         // unused jumper
  input  wire logic [`SOSC_ID_W-1:0] bus_id_in,                 // id jumpers
  input  wire logic                  diff_sense_in,             // high = lvd
  input  wire logic                  start_unit_in,             // command pulse
  input  wire logic                  wb_cyc_in,                 // wishbone cyc
  input  wire logic                  wb_stb_in,                 // wishbone stb
  input  wire logic                  wb_we_in,                  // write enable
  input  wire logic [7:0]            wb_adr_in,                 // byte address
  input  wire logic [3:0]            wb_sel_in,                 // byte selects
  input  wire logic [31:0]           wb_dat_in,                 // write data
  output logic      [31:0]           wb_dat_out,                // read data
  output logic                       wb_ack_out,                // ack
  output logic                       lvd_mode_out,              // 1 = lvd
  output logic                       spindle_run_out,           // spin motor
  output logic                       write_protect_out,         // refuse writes
  output logic                       parity_check_out,          // check parity
  output logic                       parity_report_out          // report errors
);
  import sosc_pkg::*;

  sosc_state_t            state;
  sosc_state_t            next_state;
  logic                   latched;
  logic                   s_se;
  logic                   s_ds;
  logic                   s_me;
  logic                   s_wp;
  logic                   s_pd;
  logic                   s_res;
  logic [`SOSC_ID_W-1:0]  s_id;
  logic [`SOSC_CNT_W-1:0] step_cnt;
  logic [`SOSC_ID_W-1:0]  steps_left;
  logic                   sw_start;
  logic                   start_req;

  wire wb_req    = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  // the write lands on the edge at which the master sees ack, not before
  wire wr_ctrl   = wb_cyc_in & wb_stb_in & wb_ack_out & wb_we_in
                   & wb_sel_in[0] & (wb_adr_in == `SOSC_ADDR_CTRL);
  wire step_done = (step_cnt == SPIN_STEP_CYC - 1'b1);
  assign start_req = start_unit_in | sw_start;

  // straps are caught one clock after reset release, then frozen
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      latched <= 1'b0;
      {s_se, s_ds, s_me, s_wp, s_pd, s_res} <= 6'h00;
      s_id <= '0;
    end
    else if (!latched)
    begin
      latched <= 1'b1;
      s_se  <= force_single_ended_strap_in;
      s_ds  <= delayed_spin_strap_in;
      s_me  <= motor_start_by_command_strap_in;
      s_wp  <= write_protect_strap_in;
      s_pd  <= parity_disable_strap_in;
      s_res <= reserved_strap_in;
      s_id  <= bus_id_in;
    end
  end

  always_comb
  begin
    next_state = state;
    unique case (state)
      SOSC_LATCH:
      begin
        if (latched)
        begin
          if (s_me)
            next_state = SOSC_HOLD;
          else if (s_ds && s_id != '0)
            next_state = SOSC_WAIT;
          else
            next_state = SOSC_SPIN;
        end
      end
      SOSC_WAIT:
        if (step_done && steps_left == 4'h1)
          next_state = SOSC_SPIN;
      SOSC_HOLD:
        if (start_req)
          next_state = SOSC_SPIN;
      SOSC_SPIN:
        next_state = SOSC_SPIN;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      state <= SOSC_LATCH;
    else
      state <= next_state;
  end

  // one 12 s step per unit of id
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      step_cnt   <= '0;
      steps_left <= '0;
    end
    else if (state == SOSC_LATCH)
    begin
      step_cnt   <= '0;
      steps_left <= s_id;
    end
    else if (state == SOSC_WAIT)
    begin
      if (step_done)
      begin
        step_cnt   <= '0;
        steps_left <= steps_left - 1'b1;
      end
      else
        step_cnt <= step_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      sw_start <= 1'b0;
    else
      sw_start <= wr_ctrl & wb_dat_in[`SOSC_CTRL_START_BIT];
  end

  // option outputs; all safe until straps are latched
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      lvd_mode_out      <= 1'b0;
      spindle_run_out   <= 1'b0;
      write_protect_out <= 1'b1;
      parity_check_out  <= 1'b0;
      parity_report_out <= 1'b0;
    end
    else
    begin
      lvd_mode_out      <= latched & ~s_se
                           & diff_sense_in;
      spindle_run_out   <= (state == SOSC_SPIN);
      write_protect_out <= ~latched | s_wp;
      parity_check_out  <= latched & ~s_pd;
      parity_report_out <= latched & ~s_pd;
    end
  end

  wire [31:0] rd_status = {28'h000_0000, latched, spindle_run_out,
                           state};
  wire [31:0] rd_straps = {20'h0_0000, s_id, 2'b00, s_res, s_pd, s_wp,
                           s_me, s_ds, s_se};
  wire [31:0] rd_delay  = {28'h000_0000, steps_left};
  wire [31:0] rd_mux    = (wb_adr_in == `SOSC_ADDR_STATUS) ? rd_status :
                          (wb_adr_in == `SOSC_ADDR_STRAPS) ? rd_straps :
                          (wb_adr_in == `SOSC_ADDR_DELAY)  ? rd_delay  :
                          32'h0000_0000;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_out <= wb_req;
      wb_dat_out <= wb_req ? rd_mux : 32'h0000_0000;
    end
  end

  logic [`SOSC_WAIT_W-1:0] spin_wait_cyc;
  // ideal wait: id whole steps plus the fixed latch-to-spin latency
  wire  [`SOSC_WAIT_W-1:0] spin_due_cyc =
    {{`SOSC_CNT_W{1'b0}}, s_id} * {{`SOSC_ID_W{1'b0}}, SPIN_STEP_CYC}
    + `SOSC_SPIN_LAT_CYC;

  // cycles from strap latch to spindle on, tallied apart from the delay
  // counter so the start-up checks do not lean on the logic they watch
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      spin_wait_cyc <= '0;
    else if (latched && !spindle_run_out)
      spin_wait_cyc <= spin_wait_cyc + 1'b1;
  end

  // a fresh latch, and a start command seen while held
  sequence s_fresh_latch;
    $rose(latched);
  endsequence

  sequence s_start_in_hold;
    state == SOSC_HOLD && start_req;
  endsequence

  a_spin_immediate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_fresh_latch ##0 (!s_me && !(s_ds && s_id != '0))
    |-> ##2 spindle_run_out)
    else $error("spindle did not start at once");

  a_hold_for_cmd: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == SOSC_HOLD && !start_req |=> state == SOSC_HOLD)
    else $error("spindle left hold without start");

  a_cmd_overrides: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    latched && s_me |-> state != SOSC_WAIT)
    else $error("id delay used with command strap");

  a_wait_no_spin: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == SOSC_WAIT |=> !spindle_run_out)
    else $error("spindle ran during delay");

  a_straps_frozen: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    latched |=> $stable(s_se) && $stable(s_ds) && $stable(s_me)
    && $stable(s_wp) && $stable(s_pd) && $stable(s_res)
    && $stable(s_id))
    else $error("strap changed after latch");

  a_single_ended: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    latched && $past(latched) && s_se |-> !lvd_mode_out)
    else $error("lvd chosen with force strap");

  a_sense_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    latched && !s_se |=> lvd_mode_out == $past(diff_sense_in))
    else $error("mode not following sense");

  a_write_prot: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    latched |=> write_protect_out == s_wp)
    else $error("write protect mismatch");

  a_parity_opt: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    latched |=> parity_check_out == !s_pd
    && parity_report_out == !s_pd)
    else $error("parity option mismatch");

  a_cmd_starts: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_start_in_hold |-> ##2 spindle_run_out)
    else $error("spindle did not start on command");

  a_delay_length: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(spindle_run_out) && s_ds && !s_me
    |-> spin_wait_cyc == spin_due_cyc)
    else $error("delayed start came at the wrong time");

  a_start_latency: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(spindle_run_out) && !s_ds && !s_me
    |-> spin_wait_cyc == `SOSC_SPIN_LAT_CYC)
    else $error("immediate start came at the wrong time");

  a_safe_at_power: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !latched |=> write_protect_out && !spindle_run_out
    && !parity_report_out)
    else $error("option outputs not safe before latch");

  // no stop command exists, so a running spindle must stay running
  a_spin_stays: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    spindle_run_out |=> spindle_run_out)
    else $error("spindle stopped after start");

  a_ack_answer: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("bus request not acknowledged");

  a_ack_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");
endmodule : sosc_top

// *** core/sosc_consts.svh ***
// strap-option startup controller constants
`ifndef SOSC_CONSTS_SVH
`define SOSC_CONSTS_SVH
`define SOSC_CLK_PERIOD_NS   10
`define SOSC_SPIN_STEP_S     12
// divide first so the product stays inside 32-bit integer arithmetic
`define SOSC_CYC_PER_S       (1000000000 / `SOSC_CLK_PERIOD_NS)
`define SOSC_SPIN_STEP_CYC   (`SOSC_SPIN_STEP_S * `SOSC_CYC_PER_S)
`define SOSC_ADDR_CTRL       8'h00
`define SOSC_ADDR_STATUS     8'h04
`define SOSC_ADDR_STRAPS     8'h08
`define SOSC_ADDR_DELAY      8'h0C
`define SOSC_CTRL_START_BIT  0
`define SOSC_ID_W            4
`define SOSC_CNT_W           32
// start-up tally width: step counter plus id bits
`define SOSC_WAIT_W          36
// edges from strap latch to the spindle output rising, no delay
`define SOSC_SPIN_LAT_CYC    36'h0_0000_0002
`endif

// *** core/sosc_pkg.sv ***
// types for the strap-option startup controller
package sosc_pkg;
  typedef enum logic [1:0]
  {
    SOSC_LATCH   = 2'b00,
    SOSC_WAIT    = 2'b01,
    SOSC_SPIN    = 2'b11,
    SOSC_HOLD    = 2'b10
  } sosc_state_t;
endpackage : sosc_pkg

// *** testbench/sosc_host_model.sv ***
// host adapter and jumper strap model for the startup controller bench
module sosc_host_model
(
  input  wire logic       clk_in,    // bench clock
  input  wire logic [9:0] cfg_in,    // wanted id and jumpers
  input  wire logic       cmd_in,    // host issues start unit
  output logic      [9:0] strap_out, // jumpers as fitted: id, res..se
  output logic            start_out  // start unit command pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  // the id comes from one header only, never the adapter's id 7, unique
  always_ff @(posedge clk_in)
  begin
    strap_out <= cfg_in;
    start_out <= cmd_in;
  end
endmodule : sosc_host_model

// *** testbench/tb.sv ***
// self-checking bench for the strap-option startup controller
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STEP = 10;
  logic        clk_in = 0, rst_n_in = 0, diff_sense_in = 0, cmd = 0;
  logic        wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0;
  logic [7:0]  wb_adr_in = 8'h00;
  logic [3:0]  wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0000_0000, wb_dat_out, r;
  logic        wb_ack_out, lvd, spin, wp, pchk, prep, start;
  logic [9:0]  cfg = 10'h000, strap;
  logic [31:0] exp_q[$];
  int          bad_count = 0, cmp_count = 0, seed = 83, cyc = 0, id;

  sosc_host_model sosc_host_model_i (.clk_in(clk_in), .cfg_in(cfg),
    .cmd_in(cmd), .strap_out(strap), .start_out(start));
  sosc_top #(.SPIN_STEP_CYC(32'(STEP))) sosc_top_i (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .force_single_ended_strap_in(strap[0]),
    .delayed_spin_strap_in(strap[1]),
    .motor_start_by_command_strap_in(strap[2]),
    .write_protect_strap_in(strap[3]), .parity_disable_strap_in(strap[4]),
    .reserved_strap_in(strap[5]), .bus_id_in(strap[9:6]),
    .diff_sense_in(diff_sense_in), .start_unit_in(start),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .lvd_mode_out(lvd),
    .spindle_run_out(spin), .write_protect_out(wp),
    .parity_check_out(pchk), .parity_report_out(prep));

  initial forever #5 clk_in = ~clk_in;
  always @(posedge clk_in) cyc <= rst_n_in ? cyc + 1 : 0;

  task automatic check(string nm, logic [31:0] seen, logic [31:0] e);
    cmp_count++;
    if (seen !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, seen);
    end
  endtask : check

  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  // one classic cycle; reads leave their expected word for the monitor
  task automatic wb(logic we, logic [7:0] a, logic [31:0] d, logic [31:0] e);
    if (!we)
      exp_q.push_back(e);
    wb_cyc_in <= 1;
    wb_stb_in <= 1;
    wb_we_in  <= we;
    wb_adr_in <= a;
    wb_dat_in <= d;
    wb_sel_in <= 4'hF;
    @(posedge clk_in);
    while (wb_ack_out !== 1'b1)
      @(posedge clk_in);
    wb_cyc_in <= 0;
    wb_stb_in <= 0;
    @(posedge clk_in);
  endtask : wb

  always @(posedge clk_in)
    if (wb_ack_out === 1'b1 && wb_we_in === 1'b0)
      check("read data", wb_dat_out, exp_q.size() ? exp_q.pop_front()
            : 32'hDEAD_BEEF);

  task automatic upto(int k);
    while (cyc < k)
      @(posedge clk_in);
  endtask : upto

  initial
  begin
    #100us;
    bad_count++;
    final_report;
  end

  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      id = (i == 5) ? 0 : 2 + int'(r[30:8] % 5);
      cfg <= {4'(id), r[3:1], i[1:0], i[2]};
      diff_sense_in <= r[0];
      rst_n_in <= 0;
      repeat (4) @(posedge clk_in);
      rst_n_in <= 1;
      upto(3);
      cfg <= ~cfg;
      upto(6);
      check("lvd", 32'(lvd), 32'(!i[2] && r[0]));
      check("wp", 32'(wp), 32'(r[1]));
      check("pchk", 32'(pchk), 32'(!r[2]));
      check("prep", 32'(prep), 32'(!r[2]));
      wb(0, 8'h08, 0, {20'h0_0000, 4'(id), 2'b00, r[3:1], i[1:0], i[2]});
      wb(0, 8'h0C, 0, {28'h000_0000, 4'(id)});
      wb(0, 8'h10, 0, 32'h0000_0000);
      if (i[1])
      begin
        upto(40);
        check("hold", 32'(spin), 0);
        if (r[1])
          wb(1, 8'h00, 32'h0000_0001, 0);
        else
        begin
          cmd <= 1;
          @(posedge clk_in);
          cmd <= 0;
        end
        repeat (5) @(posedge clk_in);
      end
      else if (i[0] && id > 0)
      begin
        upto(id * STEP + 2);
        check("delay", 32'(spin), 0);
        upto(id * STEP + 3);
      end
      check("spin", 32'(spin), 1);
      $display("test %0d done", i);
    end
    final_report;
  end
endmodule : tb
